// *** src/adc_pins_defs.svh ***
// Timing counts, address codes and pin encodings for the converter pin logic.
// Assumes the block clock runs at 100 MHz; counts are derived from that period.
`ifndef ADC_PINS_DEFS_SVH
`define ADC_PINS_DEFS_SVH

// Clock period of the block clock
`define CLK_PERIOD_NS      10
// Least power-up time between convert-start rising edge and sampling
`define POWER_UP_TIME_NS   1000
// Least time rounds up to whole cycles
`define POWER_UP_CYCLES    ((`POWER_UP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Conversion time of the internal oscillator, a plain default
`define CONV_TIME_NS       2000
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)

// Decoded level of the three-state address select pin
`define ASEL_GROUND        2'h0
`define ASEL_SUPPLY        2'h1
`define ASEL_FLOAT         2'h2

// Seven-bit target addresses
`define ADDR_FLOAT         7'h20
`define ADDR_V0_GROUND     7'h21
`define ADDR_V0_SUPPLY     7'h22
`define ADDR_V1_GROUND     7'h23
`define ADDR_V1_SUPPLY     7'h24

// Result width and byte split
`define RESULT_W           12
`define RESULT_HI_LSB      8

`endif

// *** src/adc_pins_pkg.sv ***
// Types shared by the converter pin logic.
// Assumes the defs header supplies all numeric constants.
package adc_pins_pkg;

	// Converter power and conversion sequence
	typedef enum logic [1:0] {
		CONV_SHUTDOWN,
		CONV_POWERING,
		CONV_READY,
		CONV_BUSY
	} conv_state_type;

	// Serial target phases
	typedef enum logic [2:0] {
		SER_IDLE,
		SER_ADDR,
		SER_ADDR_ACK,
		SER_WR_BYTE,
		SER_WR_ACK,
		SER_RD_BYTE,
		SER_RD_ACK
	} ser_state_type;

endpackage : adc_pins_pkg

// *** src/conv_sequencer.sv ***
// Convert-start sequencer: power-up timing, hold, conversion and shutdown.
// Assumes convert-start edges arrive already synchronised to CLK as pulses.
`timescale 1ns/100ps
`include "adc_pins_defs.svh"

module conv_sequencer (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Synchronised convert-start edges
	input  wire logic                   start_rise,
	input  wire logic                   start_fall,
	// Sample from the analog side, taken at end of conversion
	input  wire logic [`RESULT_W-1:0]   sample,
	// Status
	output logic                        powered,
	output logic                        holding,
	output logic                        converting,
	output logic                        done,
	output logic                        invalid,
	output logic [`RESULT_W-1:0]        result
);

	adc_pins_pkg::conv_state_type state;
	logic [8:0]                   count;
	logic                         early;

	// Sequence: comes out of reset shut down, returns there after each result
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= adc_pins_pkg::CONV_SHUTDOWN;
			count <= 9'h000;
			early <= 1'b0;
		end else begin
			unique case (state)
				adc_pins_pkg::CONV_SHUTDOWN: begin
					if (start_rise) begin
						state <= adc_pins_pkg::CONV_POWERING;
						count <= 9'h000;
					end
				end
				adc_pins_pkg::CONV_POWERING: begin
					if (start_fall) begin
						// Too short a high pulse still converts, result marked bad;
						// a fall on the last powering cycle has had its full time
						state <= adc_pins_pkg::CONV_BUSY;
						early <= (count != 9'(`POWER_UP_CYCLES - 1));
						count <= 9'h000;
					end else if (count == 9'(`POWER_UP_CYCLES - 1)) begin
						state <= adc_pins_pkg::CONV_READY;
					end else begin
						count <= count + 9'h001;
					end
				end
				adc_pins_pkg::CONV_READY: begin
					if (start_fall) begin
						state <= adc_pins_pkg::CONV_BUSY;
						early <= 1'b0;
						count <= 9'h000;
					end
				end
				adc_pins_pkg::CONV_BUSY: begin
					if (count == 9'(`CONV_CYCLES - 1)) begin
						state <= adc_pins_pkg::CONV_SHUTDOWN;
					end else begin
						count <= count + 9'h001;
					end
				end
			endcase
		end
	end

	// Result capture and completion pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			result  <= '0;
			done    <= 1'b0;
			invalid <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state == adc_pins_pkg::CONV_BUSY && count == 9'(`CONV_CYCLES - 1)) begin
				result  <= sample;
				done    <= 1'b1;
				invalid <= early;
			end
		end
	end

	assign powered    = (state != adc_pins_pkg::CONV_SHUTDOWN);
	assign holding    = (state == adc_pins_pkg::CONV_BUSY);
	assign converting = (state == adc_pins_pkg::CONV_BUSY);

endmodule : conv_sequencer

// *** src/adc_trigger_address_alert_pins.sv ***
// Pin logic of a four-channel serial-attached converter: address select,
// convert-start sequencing, shared open-drain alert/busy pin, serial target.
// Assumes SCL, SDA, convert-start and address select come from pins outside
// the CLK domain; configuration and limits come from logic on CLK.
`timescale 1ns/100ps
`include "adc_pins_defs.svh"

module adc_trigger_address_alert_pins (
	// Clock and reset
	input  wire logic                   CLK,
	input  wire logic                   NRST,
	// Address select pin level, pre-decoded by the pad, and variant strap
	input  wire logic [1:0]             ADDRESS_SELECT_PIN,
	input  wire logic                   VARIANT_STRAP,
	// Convert-start pin
	input  wire logic                   CONVERT_START_PIN,
	// Analog side
	input  wire logic [`RESULT_W-1:0]   SAMPLE_VALUE,
	output logic                        POWERED_UP,
	output logic                        TRACK_HOLD,
	// Configuration and limits
	input  wire logic                   STATUS_IS_BUSY,
	input  wire logic                   ALERT_ENABLE,
	input  wire logic                   ALERT_CLEAR,
	input  wire logic [`RESULT_W-1:0]   UPPER_LIMIT_VALUE,
	input  wire logic [`RESULT_W-1:0]   LOWER_LIMIT_VALUE,
	// Conversion results
	output logic [`RESULT_W-1:0]        RESULT,
	output logic                        RESULT_DONE,
	output logic                        RESULT_INVALID,
	output logic                        ALERT_FLAG,
	// Shared open-drain alert/busy pin
	output logic                        STATUS_OUT,
	output logic                        STATUS_OE,
	// Serial bus pins
	input  wire logic                   SCL_IN,
	input  wire logic                   SDA_IN,
	output logic                        SDA_OUT,
	output logic                        SDA_OE,
	// Serial bus user side
	output logic [6:0]                  OWN_ADDRESS,
	output logic                        ADDRESSED,
	output logic [7:0]                  WRITE_DATA,
	output logic                        WRITE_STROBE
);

	// Pin synchronisers: first stage read only by second stage
	logic [1:0] asel_meta, asel_sync;
	logic       start_meta, start_sync, start_prev;
	logic       scl_meta, scl_sync, scl_prev;
	logic       sda_meta, sda_sync, sda_prev;

	// Conversion side
	logic       start_rise, start_fall;
	logic       converting, conv_done, conv_done_q;
	logic       variant, strap_taken, strap_meta, strap_wait;
	logic       above, below;
	logic [6:0] next_address;

	// Serial target side
	adc_pins_pkg::ser_state_type ser_state;
	logic [2:0] bit_count;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic       ack_phase;
	logic       master_ack;
	logic       read_dir;
	logic       byte_sel;
	logic       scl_rise, scl_fall, bus_start, bus_stop;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;

	// Address for a given select level and variant
	function automatic logic [6:0] target_address(input logic [1:0] level,
	                                              input logic       var1);
		logic [6:0] addr;
		addr = `ADDR_FLOAT;
		if (level == `ASEL_GROUND) begin
			addr = var1 ? `ADDR_V1_GROUND : `ADDR_V0_GROUND;
		end else if (level == `ASEL_SUPPLY) begin
			addr = var1 ? `ADDR_V1_SUPPLY : `ADDR_V0_SUPPLY;
		end
		return addr;
	endfunction : target_address

	// Two-flop synchronisers for every pin input
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			asel_meta  <= `ASEL_FLOAT;
			asel_sync  <= `ASEL_FLOAT;
			start_meta <= 1'b0;
			start_sync <= 1'b0;
			start_prev <= 1'b0;
			scl_meta   <= 1'b1;
			scl_sync   <= 1'b1;
			scl_prev   <= 1'b1;
			sda_meta   <= 1'b1;
			sda_sync   <= 1'b1;
			sda_prev   <= 1'b1;
		end else begin
			asel_meta  <= ADDRESS_SELECT_PIN;
			asel_sync  <= asel_meta;
			start_meta <= CONVERT_START_PIN;
			start_sync <= start_meta;
			start_prev <= start_sync;
			scl_meta   <= SCL_IN;
			scl_sync   <= scl_meta;
			scl_prev   <= scl_sync;
			sda_meta   <= SDA_IN;
			sda_sync   <= sda_meta;
			sda_prev   <= sda_sync;
		end
	end

	// Edges seen only on synchronised copies
	assign start_rise = start_sync & ~start_prev;
	assign start_fall = ~start_sync & start_prev;
	assign scl_rise   = scl_sync & ~scl_prev;
	assign scl_fall   = ~scl_sync & scl_prev;
	assign bus_start  = scl_sync & scl_prev & sda_prev & ~sda_sync;
	assign bus_stop   = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// Strap passes two flops and is caught on the second edge after release
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strap_meta  <= 1'b0;
			strap_wait  <= 1'b0;
			variant     <= 1'b0;
			strap_taken <= 1'b0;
		end else begin
			strap_meta <= VARIANT_STRAP;
			strap_wait <= 1'b1;
			if (strap_wait && !strap_taken) begin
				variant     <= strap_meta;
				strap_taken <= 1'b1;
			end
		end
	end

	// Address follows the select pin every cycle; a change before the address ack applies to the current transfer
	assign next_address = target_address(asel_sync, variant);
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			OWN_ADDRESS <= `ADDR_FLOAT;
		end else begin
			OWN_ADDRESS <= next_address;
		end
	end

	// Convert-start sequencing and result capture
	conv_sequencer u_seq (
		.clk        (CLK),
		.nrst       (NRST),
		.start_rise (start_rise),
		.start_fall (start_fall),
		.sample     (SAMPLE_VALUE),
		.powered    (POWERED_UP),
		.holding    (TRACK_HOLD),
		.converting (converting),
		.done       (conv_done),
		.invalid    (RESULT_INVALID),
		.result     (RESULT)
	);
	assign RESULT_DONE = conv_done;

	// Limit check on the newly captured result
	assign above = (RESULT > UPPER_LIMIT_VALUE);
	assign below = (RESULT < LOWER_LIMIT_VALUE);

	// Sticky alert: a violation in the clear cycle is kept, set beats clear
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ALERT_FLAG <= 1'b0;
		end else if (conv_done_q && (above || below)) begin
			ALERT_FLAG <= 1'b1;
		end else if (ALERT_CLEAR) begin
			ALERT_FLAG <= 1'b0;
		end
	end

	// Check one cycle after the done pulse, with the new result settled
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			conv_done_q <= 1'b0;
		end else begin
			conv_done_q <= conv_done;
		end
	end

	// Shared pin only ever pulls low; the enable carries the active state
	assign STATUS_OUT = 1'b0;
	assign STATUS_OE  = STATUS_IS_BUSY ? converting
	                                   : (ALERT_FLAG & ALERT_ENABLE);

	// Byte that the controller reads: result high bits, then low byte
	assign tx_byte = byte_sel ? RESULT[7:0]
	                          : {4'h0, RESULT[`RESULT_W-1:`RESULT_HI_LSB]};
	assign rx_byte = {rx_shift[6:0], sda_sync};

	// Serial target: bits taken on SCL rise, SDA changed on SCL fall
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ser_state  <= adc_pins_pkg::SER_IDLE;
			bit_count  <= 3'h0;
			rx_shift   <= 8'h00;
			tx_shift   <= 8'h00;
			ack_phase  <= 1'b0;
			master_ack <= 1'b0;
			read_dir   <= 1'b0;
			byte_sel   <= 1'b0;
			SDA_OE     <= 1'b0;
		end else if (bus_start) begin
			ser_state <= adc_pins_pkg::SER_ADDR;
			bit_count <= 3'h0;
			ack_phase <= 1'b0;
			byte_sel  <= 1'b0;
			SDA_OE    <= 1'b0;
		end else if (bus_stop) begin
			ser_state <= adc_pins_pkg::SER_IDLE;
			SDA_OE    <= 1'b0;
		end else begin
			unique case (ser_state)
				adc_pins_pkg::SER_IDLE: begin
					SDA_OE <= 1'b0;
				end
				adc_pins_pkg::SER_ADDR, adc_pins_pkg::SER_WR_BYTE: begin
					if (scl_rise) begin
						rx_shift  <= rx_byte;
						bit_count <= bit_count + 3'h1;
						if (bit_count == 3'h7) begin
							ser_state <= (ser_state == adc_pins_pkg::SER_ADDR)
							             ? adc_pins_pkg::SER_ADDR_ACK
							             : adc_pins_pkg::SER_WR_ACK;
						end
					end
				end
				adc_pins_pkg::SER_ADDR_ACK: begin
					if (scl_fall && !ack_phase) begin
						if (rx_shift[7:1] == OWN_ADDRESS) begin
							ack_phase <= 1'b1;
							read_dir  <= rx_shift[0];
							SDA_OE    <= 1'b1;
						end else begin
							ser_state <= adc_pins_pkg::SER_IDLE;
						end
					end else if (scl_fall) begin
						ack_phase <= 1'b0;
						if (read_dir) begin
							ser_state <= adc_pins_pkg::SER_RD_BYTE;
							tx_shift  <= {tx_byte[6:0], 1'b0};
							SDA_OE    <= ~tx_byte[7];
							byte_sel  <= ~byte_sel;
						end else begin
							ser_state <= adc_pins_pkg::SER_WR_BYTE;
							SDA_OE    <= 1'b0;
						end
					end
				end
				adc_pins_pkg::SER_WR_ACK: begin
					if (scl_fall && !ack_phase) begin
						ack_phase <= 1'b1;
						SDA_OE    <= 1'b1;
					end else if (scl_fall) begin
						ack_phase <= 1'b0;
						SDA_OE    <= 1'b0;
						ser_state <= adc_pins_pkg::SER_WR_BYTE;
					end
				end
				adc_pins_pkg::SER_RD_BYTE: begin
					if (scl_fall) begin
						bit_count <= bit_count + 3'h1;
						if (bit_count == 3'h7) begin
							SDA_OE    <= 1'b0;                        // Release for master ack
							ser_state <= adc_pins_pkg::SER_RD_ACK;
						end else begin
							SDA_OE   <= ~tx_shift[7];
							tx_shift <= {tx_shift[6:0], 1'b0};
						end
					end
				end
				adc_pins_pkg::SER_RD_ACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_sync;
					end else if (scl_fall && master_ack) begin
						ser_state <= adc_pins_pkg::SER_RD_BYTE;
						tx_shift  <= {tx_byte[6:0], 1'b0};
						SDA_OE    <= ~tx_byte[7];
						byte_sel  <= ~byte_sel;
					end else if (scl_fall) begin
						ser_state <= adc_pins_pkg::SER_IDLE;      // Not-ack ends the read
					end
				end
				default: begin
					ser_state <= adc_pins_pkg::SER_IDLE;
				end
			endcase
		end
	end

	// Received bytes handed to the user side with a one-cycle strobe
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			WRITE_DATA   <= 8'h00;
			WRITE_STROBE <= 1'b0;
		end else begin
			WRITE_STROBE <= 1'b0;
			if (ser_state == adc_pins_pkg::SER_WR_ACK && scl_fall && !ack_phase) begin
				WRITE_DATA   <= rx_shift;
				WRITE_STROBE <= 1'b1;
			end
		end
	end

	// SDA only ever pulls low
	assign SDA_OUT   = 1'b0;
	assign ADDRESSED = (ser_state != adc_pins_pkg::SER_IDLE)
	                && (ser_state != adc_pins_pkg::SER_ADDR)
	                && (ser_state != adc_pins_pkg::SER_ADDR_ACK || ack_phase);

endmodule : adc_trigger_address_alert_pins

// *** tb/adc_pins_checker.sv ***
// Checker for the converter pin logic, bound to its top module.
// Assumes the defs header is on the include path.
`timescale 1ns/100ps
`include "adc_pins_defs.svh"
module adc_pins_checker (
	// Clock and reset
	input wire logic                 CLK,
	input wire logic                 NRST,
	// Pins and configuration
	input wire logic [1:0]           ADDRESS_SELECT_PIN,
	input wire logic                 CONVERT_START_PIN,
	input wire logic                 STATUS_IS_BUSY,
	input wire logic                 ALERT_ENABLE,
	input wire logic [`RESULT_W-1:0] UPPER_LIMIT_VALUE,
	input wire logic [`RESULT_W-1:0] LOWER_LIMIT_VALUE,
	// Design outputs
	input wire logic                 POWERED_UP,
	input wire logic                 TRACK_HOLD,
	input wire logic [`RESULT_W-1:0] RESULT,
	input wire logic                 RESULT_DONE,
	input wire logic                 ALERT_FLAG,
	input wire logic                 STATUS_OUT,
	input wire logic                 STATUS_OE,
	input wire logic                 SDA_OUT,
	input wire logic [6:0]           OWN_ADDRESS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Open-drain pins only ever pull low
	a_status_open_drain: assert property (STATUS_OUT == 1'h0)
		else $error("status pin driven high");
	a_sda_open_drain: assert property (SDA_OUT == 1'h0)
		else $error("data pin driven high");
	// Start rise in shutdown powers the converter within the sync delay
	a_rise_powers: assert property ($rose(CONVERT_START_PIN) && !POWERED_UP |-> ##[2:5] POWERED_UP)
		else $error("no power-up after start rise");
	a_hold_length: assert property ($rose(TRACK_HOLD) |-> ##[199:201] RESULT_DONE)
		else $error("conversion length wrong");
	a_done_shutdown: assert property (RESULT_DONE |-> !POWERED_UP && !TRACK_HOLD)
		else $error("not shut down after conversion");
	// Mode is only trusted once it has been steady a few cycles
	a_busy_follows: assert property (STATUS_IS_BUSY [*4] |-> STATUS_OE == TRACK_HOLD)
		else $error("busy pin differs from conversion");
	a_alert_gated: assert property ((!STATUS_IS_BUSY) [*4] |-> STATUS_OE == (ALERT_FLAG && ALERT_ENABLE))
		else $error("alert pin differs from gated flag");
	a_alert_sets: assert property (RESULT_DONE ##1 (RESULT > UPPER_LIMIT_VALUE || RESULT < LOWER_LIMIT_VALUE) |-> ##[0:1] ALERT_FLAG)
		else $error("limit violation not flagged");
	a_float_addr: assert property ((ADDRESS_SELECT_PIN == `ASEL_FLOAT) [*6] |-> OWN_ADDRESS == `ADDR_FLOAT)
		else $error("floating select gives wrong address");
	c_done: cover property (RESULT_DONE);
	c_alert_pin: cover property (STATUS_OE && !STATUS_IS_BUSY);
	c_busy_pin: cover property (STATUS_OE && STATUS_IS_BUSY);
endmodule : adc_pins_checker

bind adc_trigger_address_alert_pins adc_pins_checker chk (.CLK(CLK), .NRST(NRST),
	.ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN), .CONVERT_START_PIN(CONVERT_START_PIN),
	.STATUS_IS_BUSY(STATUS_IS_BUSY), .ALERT_ENABLE(ALERT_ENABLE),
	.UPPER_LIMIT_VALUE(UPPER_LIMIT_VALUE), .LOWER_LIMIT_VALUE(LOWER_LIMIT_VALUE),
	.POWERED_UP(POWERED_UP), .TRACK_HOLD(TRACK_HOLD), .RESULT(RESULT),
	.RESULT_DONE(RESULT_DONE), .ALERT_FLAG(ALERT_FLAG), .STATUS_OUT(STATUS_OUT),
	.STATUS_OE(STATUS_OE), .SDA_OUT(SDA_OUT), .OWN_ADDRESS(OWN_ADDRESS));

// *** tb/i2c_ctrl_model.sv ***
// Serial bus controller model driving SCL and its side of SDA.
// Assumes a pull-up on SDA: the wire is high unless someone pulls it.
`timescale 1ns/100ps
module i2c_ctrl_model (
	// Device pull-down on the data wire
	input wire logic dev_sda_oe,
	// Bus wires
	output logic     scl,
	output logic     sda
);
	logic pull;
	// Wired-and with the pull-up, so a released wire never keeps a stale value
	assign sda = !(pull || dev_sda_oe);
	// SCL stands high between frames
	initial begin
		pull = 1'h0;
		scl = 1'h1;
	end
	// One 125 ns bit; data moves only while SCL is low
	task bit_io(input logic b, output logic got);
		pull = !b;
		#31.25 scl = 1'h1;
		#31.25 got = sda;
		#31.25 scl = 1'h0;
		#31.25;
	endtask : bit_io
	// Start, address with write bit, one byte, stop; acks reported as seen
	task write(input logic [6:0] addr, input logic [7:0] data, output logic ack_a,
		output logic ack_d);
		logic g;
		logic [7:0] b;
		pull = 1'h1;
		#62.5 scl = 1'h0;
		#31.25;
		b = {addr, 1'h0};
		for (int i = 7; i >= 0; i--) bit_io(b[i], g);
		bit_io(1'h1, g);
		ack_a = !g;
		for (int i = 7; i >= 0; i--) bit_io(data[i], g);
		bit_io(1'h1, g);
		ack_d = !g;
		pull = 1'h1;
		#31.25 scl = 1'h1;
		#31.25 pull = 1'h0;
		#62.5;
	endtask : write
	// Start, address with read bit, two bytes (ack, then not-ack), stop
	task read(input logic [6:0] addr, output logic ack_a, output logic [15:0] data);
		logic g;
		logic [7:0] b;
		pull = 1'h1;
		#62.5 scl = 1'h0;
		#31.25;
		b = {addr, 1'h1};
		for (int i = 7; i >= 0; i--) bit_io(b[i], g);
		bit_io(1'h1, g);
		ack_a = !g;
		for (int i = 15; i >= 0; i--) begin
			bit_io(1'h1, g);
			data[i] = g;
			if (i == 8) bit_io(1'h0, g);
		end
		bit_io(1'h1, g);
		pull = 1'h1;
		#31.25 scl = 1'h1;
		#31.25 pull = 1'h0;
		#62.5;
	endtask : read
endmodule : i2c_ctrl_model

// *** tb/tb_adc_trigger_address_alert_pins.sv ***
// Testbench for the converter pin logic: address select, conversions, status pin, bus.
// Assumes the checker binds itself and the controller model sits on the bus.
`timescale 1ns/100ps
`include "adc_pins_defs.svh"
module tb_adc_trigger_address_alert_pins;
	logic clk, nrst, variant, start_pin, powered, hold, busy_mode, alert_en, alert_clr;
	logic done, invalid, alert, st_out, st_oe, scl, sda, sda_out, sda_oe, addressed;
	logic wr_strobe, aa, ad;
	logic [1:0] asel;
	logic [6:0] own_addr;
	logic [7:0] wr_data;
	logic [15:0] rd;
	logic [11:0] sample, upper, lower, result;
	logic [1:0] tsel[4] = '{`ASEL_GROUND, `ASEL_SUPPLY, `ASEL_GROUND, `ASEL_SUPPLY};
	logic [6:0] taddr[4] = '{`ADDR_V0_GROUND, `ADDR_V0_SUPPLY, `ADDR_V1_GROUND, `ADDR_V1_SUPPLY};
	int n_fail, n_checks, n_strobe, n_oe, n_adr, s0, o0, a0;

	adc_trigger_address_alert_pins uut (.CLK(clk), .NRST(nrst), .ADDRESS_SELECT_PIN(asel),
		.VARIANT_STRAP(variant), .CONVERT_START_PIN(start_pin), .SAMPLE_VALUE(sample),
		.POWERED_UP(powered), .TRACK_HOLD(hold), .STATUS_IS_BUSY(busy_mode),
		.ALERT_ENABLE(alert_en), .ALERT_CLEAR(alert_clr), .UPPER_LIMIT_VALUE(upper),
		.LOWER_LIMIT_VALUE(lower), .RESULT(result), .RESULT_DONE(done),
		.RESULT_INVALID(invalid), .ALERT_FLAG(alert), .STATUS_OUT(st_out),
		.STATUS_OE(st_oe), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.OWN_ADDRESS(own_addr), .ADDRESSED(addressed), .WRITE_DATA(wr_data),
		.WRITE_STROBE(wr_strobe));
	i2c_ctrl_model ctrl (.dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

	// Clock, 100 MHz
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Strobe and bus-drive counts, for transfers that must leave no trace
	always @(posedge clk) begin
		n_strobe += wr_strobe;
		n_oe += sda_oe;
		n_adr += addressed;
	end
	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// Variant strap is caught just after reset release
	task do_reset(input logic v);
		nrst = 1'h0;
		variant = v;
		tick(20);
		nrst = 1'h1;
		tick(6);
	endtask : do_reset
	// Start pulse held hi cycles, then wait for the result
	task conv(input int hi, input logic [11:0] s);
		int k;
		sample = s;
		start_pin = 1'h1;
		tick(4);
		chk(12'(powered), 12'h1);
		tick(hi - 4);
		start_pin = 1'h0;
		tick(4);
		chk(12'(hold), 12'h1);
		if (busy_mode) chk(12'(st_oe), 12'h1);
		k = 0;
		while (done !== 1'h1 && k < 300) begin
			tick(1);
			k++;
		end
		chk(12'(k < 300), 12'h1);
		tick(1);
		chk(result, s);
		chk(12'(powered), 12'h0);
	endtask : conv

	initial begin
		{nrst, variant, start_pin, busy_mode, alert_en, alert_clr} = 6'h00;
		{sample, upper, lower} = {12'h000, 12'hFFF, 12'h000};
		asel = `ASEL_FLOAT;
		do_reset(1'h0);
		chk(12'(own_addr), 12'(`ADDR_FLOAT));
		chk(12'(powered), 12'h0);
		for (int i = 0; i < 4; i++) begin
			asel = tsel[i];
			do_reset(i[1]);
			chk(12'(own_addr), 12'(taddr[i]));
		end
		asel = `ASEL_FLOAT;
		do_reset(1'h1);
		chk(12'(own_addr), 12'(`ADDR_FLOAT));
		// Busy mode, then a start pulse too short to power up
		busy_mode = 1'h1;
		tick(4);
		conv(120, 12'hABC);
		chk(12'({st_oe, invalid}), 12'h0);
		conv(30, 12'h123);
		chk(12'(invalid), 12'h1);
		conv(100, 12'h3C5);
		chk(12'(invalid), 12'h0);
		// Alert mode: in range, above, gated off, cleared, below
		busy_mode = 1'h0;
		alert_en = 1'h1;
		{upper, lower} = {12'h800, 12'h100};
		tick(4);
		conv(120, 12'h400);
		chk(12'({alert, st_oe}), 12'h0);
		conv(120, 12'h900);
		tick(1);
		chk(12'({alert, st_oe}), 12'h3);
		alert_en = 1'h0;
		tick(3);
		chk(12'(st_oe), 12'h0);
		alert_clr = 1'h1;
		tick(3);
		alert_clr = 1'h0;
		chk(12'(alert), 12'h0);
		alert_en = 1'h1;
		conv(120, 12'h050);
		tick(1);
		chk(12'(st_oe), 12'h1);
		// Bus write to own address, then to a stranger, then a two-byte read
		s0 = n_strobe;
		a0 = n_adr;
		ctrl.write(`ADDR_FLOAT, 8'h5A, aa, ad);
		tick(2);
		chk(12'({aa, ad}), 12'h3);
		chk(12'(wr_data), 12'h05A);
		chk(12'(n_strobe - s0), 12'h1);
		chk(12'(n_adr - a0 > 0), 12'h1);
		s0 = n_strobe;
		o0 = n_oe;
		a0 = n_adr;
		ctrl.write(`ADDR_V0_GROUND, 8'hA5, aa, ad);
		tick(2);
		chk(12'(aa), 12'h0);
		chk(12'(n_oe - o0 + n_strobe - s0 + n_adr - a0), 12'h0);
		ctrl.read(`ADDR_FLOAT, aa, rd);
		tick(2);
		chk(12'(aa), 12'h1);
		chk(12'(rd[15:12]), 12'h000);
		chk(rd[11:0], 12'h050);
		chk(12'({st_out, sda_out, addressed}), 12'h0);
		wrap_up();
	end
endmodule : tb_adc_trigger_address_alert_pins
